// ### verilog/pcm_mux.sv
// Port H/J pin-change and LCD segment mux with APB control registers.
//
// Function
// R1: LCD enable forces port H pull-ups off.
// R2: LCD enable forces input direction; output untouched.
// R3: Input enable override needs mask, group, LCD, low-power.
// R4: Port H bits feed pin-change sources 16-23.
// R5: Port H analog path drives front-plane segments.
// R6: Port J bits: sources 24-30, segments 35, 34, 31..27.
// R7: Ports H and J exist only in large variants.
// R8: LCD disabled releases every pad override.
`timescale 1ns/100ps
`default_nettype none
module pcm_mux
#(
  parameter bit LARGE_PKG = 1'b1
)
(
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [pcm_pkg::PCM_ADDR_W-1:0]         paddr,
  input  wire logic [pcm_pkg::PCM_DATA_W-1:0]         pwdata,
  output var  logic [pcm_pkg::PCM_DATA_W-1:0]         prdata,
  output var  logic                                   pready,
  output var  logic                                   pslverr,
  input  wire logic [pcm_pkg::PCM_H_W-1:0]            port_h_pullup,
  input  wire logic [pcm_pkg::PCM_H_W-1:0]            port_h_dir,
  input  wire logic [pcm_pkg::PCM_H_W-1:0]            port_h_out,
  input  wire logic [pcm_pkg::PCM_H_W-1:0]            port_h_input_enable,
  input  wire logic [pcm_pkg::PCM_J_W-1:0]            port_j_pullup,
  input  wire logic [pcm_pkg::PCM_J_W-1:0]            port_j_dir,
  input  wire logic [pcm_pkg::PCM_J_W-1:0]            port_j_out,
  input  wire logic [pcm_pkg::PCM_J_W-1:0]            port_j_input_enable,
  input  wire logic [pcm_pkg::PCM_H_W-1:0]            ph_pad_in,
  output var  logic [pcm_pkg::PCM_H_W-1:0]            ph_pad_out,
  output var  logic [pcm_pkg::PCM_H_W-1:0]            ph_pad_oe,
  output var  logic [pcm_pkg::PCM_H_W-1:0]            ph_pullup_en,
  output var  logic [pcm_pkg::PCM_H_W-1:0]            ph_input_en,
  output var  logic [pcm_pkg::PCM_H_W-1:0]            ph_analog_path,
  input  wire logic [pcm_pkg::PCM_J_W-1:0]            pj_pad_in,
  output var  logic [pcm_pkg::PCM_J_W-1:0]            pj_pad_out,
  output var  logic [pcm_pkg::PCM_J_W-1:0]            pj_pad_oe,
  output var  logic [pcm_pkg::PCM_J_W-1:0]            pj_pullup_en,
  output var  logic [pcm_pkg::PCM_J_W-1:0]            pj_input_en,
  output var  logic [pcm_pkg::PCM_J_W-1:0]            pj_analog_path,
  input  wire logic [pcm_pkg::PCM_SEG_W-1:0]          lcd_front_plane_output,
  output var  logic [pcm_pkg::PCM_PCS_TOP:pcm_pkg::PCM_PCS_H_BASE]
                                                      pin_change_source
);
  import pcm_pkg::*;

  logic [PCM_CTRL_W-1:0] ctrl;
  logic [PCM_MASK_W-1:0] mask;
  logic [PCM_CTRL_W-1:0] next_ctrl;
  logic [PCM_MASK_W-1:0] next_mask;
  logic [PCM_DATA_W-1:0] next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;
  logic                  access;
  logic                  mapped;
  logic                  lcd_enable;
  logic                  lcd_low_power_setting;
  logic                  pin_change_group_enable;
  logic [PCM_H_W-1:0]    ph_stable;
  logic [PCM_J_W-1:0]    pj_stable;
  logic [PCM_H_W-1:0]    ph_seg;
  logic [PCM_J_W-1:0]    pj_seg;
  logic [PCM_H_W-1:0]    ph_tap;
  logic [PCM_J_W-1:0]    pj_tap;

  assign lcd_enable              = ctrl[PCM_CTRL_LCD_ENABLE_BIT];
  assign lcd_low_power_setting   = ctrl[PCM_CTRL_LOWPWR_BIT];
  assign pin_change_group_enable = ctrl[PCM_CTRL_GRPEN_BIT];

  // ==========================================================================
  // APB slave
  // One wait state: pready rises in the second access cycle.
  always_comb
  begin
    access       = psel & penable;
    mapped       = pcm_hit(paddr, PCM_CTRL_OFF) | pcm_hit(paddr, PCM_MASK_OFF)
                   | pcm_hit(paddr, PCM_STAT_OFF);
    next_pready  = access & ~pready;
    next_pslverr = access & ~pready & ~mapped;
    next_ctrl    = ctrl;
    next_mask    = mask;
    next_prdata  = '0;
    if (access && pready && pwrite)
    begin
      if (pcm_hit(paddr, PCM_CTRL_OFF))
      begin
        next_ctrl = pwdata[PCM_CTRL_W-1:0];
      end
      if (pcm_hit(paddr, PCM_MASK_OFF))
      begin
        next_mask = pwdata[PCM_MASK_W-1:0];
      end
    end
    if (access && !pready && !pwrite)
    begin
      if (pcm_hit(paddr, PCM_CTRL_OFF))
      begin
        next_prdata[PCM_CTRL_W-1:0] = ctrl;
      end
      if (pcm_hit(paddr, PCM_MASK_OFF))
      begin
        next_prdata[PCM_MASK_W-1:0] = mask;
      end
      if (pcm_hit(paddr, PCM_STAT_OFF))
      begin
        next_prdata[PCM_H_W-1:0]                      = ph_tap;
        next_prdata[PCM_STAT_J_LSB +: PCM_J_W]        = pj_tap;
        next_prdata[PCM_STAT_PRESENT_BIT]             = LARGE_PKG;
      end
    end
  end

  // Register file and bus answer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl    <= PCM_CTRL_RST;
      mask    <= PCM_MASK_RST;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      ctrl    <= next_ctrl;
      mask    <= next_mask;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  pcm_sync #(.W(PCM_H_W)) u_sync_h
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_raw    (ph_pad_in),
    .pin_stable (ph_stable)
  );

  pcm_sync #(.W(PCM_J_W)) u_sync_j
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_raw    (pj_pad_in),
    .pin_stable (pj_stable)
  );

  // ==========================================================================
  // Segment selection
  // Each pin bit picks its own front-plane segment from the LCD controller.
  for (genvar i = 0; i < PCM_H_W; i++)
  begin : g_h_seg
    assign ph_seg[i] = lcd_front_plane_output[PCM_H_SEG[i]];    // R5
  end

  for (genvar i = 0; i < PCM_J_W; i++)
  begin : g_j_seg
    assign pj_seg[i] = lcd_front_plane_output[PCM_J_SEG[i]];    // R6
  end

  // ==========================================================================
  // Override cells
  pcm_port_ovr #(.W(PCM_H_W), .PRESENT(LARGE_PKG)) u_ovr_h
  (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .lcd_enable              (lcd_enable),
    .lcd_low_power_setting   (lcd_low_power_setting),
    .pin_change_group_enable (pin_change_group_enable),
    .pin_change_mask         (mask[PCM_H_W-1:0]),
    .port_pullup             (port_h_pullup),
    .port_dir                (port_h_dir),
    .port_out                (port_h_out),
    .port_input_enable       (port_h_input_enable),
    .pin_level               (ph_stable),
    .seg_level               (ph_seg),
    .pad_pullup_en           (ph_pullup_en),
    .pad_oe                  (ph_pad_oe),
    .pad_out                 (ph_pad_out),
    .pad_input_en            (ph_input_en),
    .digital_input_tap       (ph_tap),
    .analog_path             (ph_analog_path)
  );

  pcm_port_ovr #(.W(PCM_J_W), .PRESENT(LARGE_PKG)) u_ovr_j
  (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .lcd_enable              (lcd_enable),
    .lcd_low_power_setting   (lcd_low_power_setting),
    .pin_change_group_enable (pin_change_group_enable),
    .pin_change_mask         (mask[PCM_MASK_J_LSB +: PCM_J_W]),
    .port_pullup             (port_j_pullup),
    .port_dir                (port_j_dir),
    .port_out                (port_j_out),
    .port_input_enable       (port_j_input_enable),
    .pin_level               (pj_stable),
    .seg_level               (pj_seg),
    .pad_pullup_en           (pj_pullup_en),
    .pad_oe                  (pj_pad_oe),
    .pad_out                 (pj_pad_out),
    .pad_input_en            (pj_input_en),
    .digital_input_tap       (pj_tap),
    .analog_path             (pj_analog_path)
  );

  // Source numbering: H bit i is source 16+i, J bit i is source 24+i.
  assign pin_change_source = {pj_tap, ph_tap};                  // R4 R6

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PULLUP_OFF: assert property (lcd_enable |=> (ph_pullup_en == '0)) // R1
    else $error("Port H pull-up on while LCD enabled.");

  AST_DIR_INPUT: assert property (lcd_enable |=> (ph_pad_oe == '0)) // R2
    else $error("Port H driven while LCD enabled.");

  AST_OUT_KEPT: assert property (LARGE_PKG // R2
    |=> ph_pad_out == $past(port_h_out))
    else $error("Port H output value was overridden.");

  AST_IE_OVR: assert property (LARGE_PKG |=> ph_input_en == $past( // R3
    (mask[PCM_H_W-1:0] & {PCM_H_W{pin_change_group_enable & lcd_enable
      & lcd_low_power_setting}}) | port_h_input_enable))
    else $error("Port H input enable override wrong.");

  AST_TAP_GATED: assert property ((ph_input_en == '0) // R4
    |-> (pin_change_source[23:16] == '0))
    else $error("Pin-change source live with input disabled.");

  AST_TAP_FOLLOW: assert property ((LARGE_PKG && ph_input_en[0]) // R4
    |-> pin_change_source[16] == $past(ph_stable[0]))
    else $error("Source 16 does not follow port H bit 0.");

  AST_SEG_H: assert property (LARGE_PKG |=> // R5
    (ph_analog_path[1:0] == $past({lcd_front_plane_output[9],
                                   lcd_front_plane_output[10]})))
    else $error("Port H bits 1:0 carry wrong segments.");

  AST_SEG_J: assert property (LARGE_PKG |=> pj_analog_path == $past( // R6
    {lcd_front_plane_output[27], lcd_front_plane_output[28],
     lcd_front_plane_output[29], lcd_front_plane_output[30],
     lcd_front_plane_output[31], lcd_front_plane_output[34],
     lcd_front_plane_output[35]}))
    else $error("Port J segment order wrong.");

  AST_SMALL_PKG: assert property (!LARGE_PKG |-> // R7
    (pin_change_source == '0 && ph_pad_oe == '0 && pj_pad_oe == '0))
    else $error("Absent ports show activity.");

  AST_RELEASE: assert property (!lcd_enable |=> // R8
    (ph_pad_oe == $past(port_h_dir) && pj_pullup_en == $past(port_j_pullup))
    || !LARGE_PKG)
    else $error("Overrides held with LCD disabled.");

  AST_APB_WAIT: assert property ((psel && penable && !pready) |=> pready)
    else $error("APB answer missing after one wait state.");

  COV_LCD_ON: cover property (!lcd_enable ##1 lcd_enable);
  COV_IE_OVR: cover property (lcd_enable && lcd_low_power_setting
    && pin_change_group_enable && mask != '0);
  COV_WRITE: cover property (psel && penable && pready && pwrite);
  COV_PIN_EDGE: cover property ($rose(pin_change_source[16]));

endmodule // pcm_mux
`default_nettype wire

// ### include/pcm_pkg.sv
// Constants shared by the port H/J pin-change and LCD segment mux.
package pcm_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned PCM_ADDR_W = 8;
  localparam int unsigned PCM_DATA_W = 32;
  localparam int unsigned PCM_H_W    = 8;
  localparam int unsigned PCM_J_W    = 7;
  localparam int unsigned PCM_SEG_W  = 40;
  localparam int unsigned PCM_MASK_W = PCM_H_W + PCM_J_W;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [PCM_ADDR_W-1:0] PCM_CTRL_OFF = 8'h00;
  localparam logic [PCM_ADDR_W-1:0] PCM_MASK_OFF = 8'h04;
  localparam logic [PCM_ADDR_W-1:0] PCM_STAT_OFF = 8'h08;

  // ==========================================================================
  // Field positions
  localparam int unsigned PCM_CTRL_LCD_ENABLE_BIT   = 0;
  localparam int unsigned PCM_CTRL_LOWPWR_BIT  = 1;
  localparam int unsigned PCM_CTRL_GRPEN_BIT   = 2;
  localparam int unsigned PCM_CTRL_W           = 3;
  localparam int unsigned PCM_MASK_J_LSB       = 8;
  localparam int unsigned PCM_STAT_J_LSB       = 8;
  localparam int unsigned PCM_STAT_PRESENT_BIT = 16;

  // ==========================================================================
  // Reset values
  localparam logic [PCM_CTRL_W-1:0] PCM_CTRL_RST = 3'h0;
  localparam logic [PCM_MASK_W-1:0] PCM_MASK_RST = 15'h0000;

  // ==========================================================================
  // Pin-change source numbering and segment map per pin bit
  localparam int unsigned PCM_PCS_H_BASE = 16;
  localparam int unsigned PCM_PCS_J_BASE = 24;
  localparam int unsigned PCM_PCS_TOP    = 30;
  localparam int unsigned PCM_H_SEG [PCM_H_W] = '{10, 9, 8, 7, 39, 38, 37, 36};
  localparam int unsigned PCM_J_SEG [PCM_J_W] = '{35, 34, 31, 30, 29, 28, 27};

  // Address match used by both the write and the read decode.
  function automatic logic pcm_hit(input logic [PCM_ADDR_W-1:0] addr,
                                   input logic [PCM_ADDR_W-1:0] off);
    pcm_hit = (addr == off);
  endfunction

endpackage

// ### verilog/pcm_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/100ps
`default_nettype none
module pcm_sync
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_raw,
  output var  logic [W-1:0] pin_stable
);
  import pcm_pkg::*;

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_stable;

  // ==========================================================================
  // Filter
  // A bit changes only once stages two and three agree; stage one is unseen.
  always_comb
  begin
    next_stable = pin_stable;
    for (int i = 0; i < W; i++)
    begin
      if (s2[i] == s3[i])
      begin
        next_stable[i] = s3[i];
      end
    end
  end

  // Flip-flop chain.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1         <= '0;
      s2         <= '0;
      s3         <= '0;
      pin_stable <= '0;
    end
    else
    begin
      s1         <= pin_raw;
      s2         <= s1;
      s3         <= s2;
      pin_stable <= next_stable;
    end
  end

endmodule // pcm_sync
`default_nettype wire

// ### verilog/pcm_port_ovr.sv
// Override cell for one shared port: pad controls, input tap, segment path.
`timescale 1ns/100ps
`default_nettype none
module pcm_port_ovr
#(
  parameter int unsigned W       = 8,
  parameter bit          PRESENT = 1'b1
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         lcd_enable,
  input  wire logic         lcd_low_power_setting,
  input  wire logic         pin_change_group_enable,
  input  wire logic [W-1:0] pin_change_mask,
  input  wire logic [W-1:0] port_pullup,
  input  wire logic [W-1:0] port_dir,
  input  wire logic [W-1:0] port_out,
  input  wire logic [W-1:0] port_input_enable,
  input  wire logic [W-1:0] pin_level,
  input  wire logic [W-1:0] seg_level,
  output var  logic [W-1:0] pad_pullup_en,
  output var  logic [W-1:0] pad_oe,
  output var  logic [W-1:0] pad_out,
  output var  logic [W-1:0] pad_input_en,
  output var  logic [W-1:0] digital_input_tap,
  output var  logic [W-1:0] analog_path
);
  import pcm_pkg::*;

  logic [W-1:0] pullup_override_enable;
  logic [W-1:0] pullup_override_value;
  logic [W-1:0] direction_override_enable;
  logic [W-1:0] direction_override_value;
  logic [W-1:0] output_value_override_enable;
  logic [W-1:0] output_value_override_value;
  logic [W-1:0] input_enable_override_enable;
  logic [W-1:0] input_enable_override_value;
  logic [W-1:0] next_pullup;
  logic [W-1:0] next_oe;
  logic [W-1:0] next_out;
  logic [W-1:0] next_ie;
  logic [W-1:0] next_tap;
  logic [W-1:0] next_analog;

  // ==========================================================================
  // Override terms
  // The LCD takes pull-up and direction, never the output value.
  always_comb
  begin
    pullup_override_enable       = {W{lcd_enable}};             // R1
    pullup_override_value        = '0;                          // R1
    direction_override_enable    = {W{lcd_enable}};             // R2
    direction_override_value     = '0;                          // R2
    output_value_override_enable = '0;                          // R2
    output_value_override_value  = '0;
    input_enable_override_enable = pin_change_mask
      & {W{pin_change_group_enable & lcd_enable
           & lcd_low_power_setting}};                           // R3
    input_enable_override_value  = '1;
  end

  // Resolve each pad control; a cleared enable hands back the port value.
  always_comb
  begin
    next_pullup = (pullup_override_enable & pullup_override_value)
      | (~pullup_override_enable & port_pullup);                // R8
    next_oe     = (direction_override_enable & direction_override_value)
      | (~direction_override_enable & port_dir);                // R8
    next_out    = (output_value_override_enable
      & output_value_override_value)
      | (~output_value_override_enable & port_out);
    next_ie     = (input_enable_override_enable
      & input_enable_override_value)
      | (~input_enable_override_enable & port_input_enable);    // R8
    next_tap    = pin_level & next_ie;                          // R4
    next_analog = seg_level;                                    // R5
    if (!PRESENT)
    begin
      next_pullup = '0;                                         // R7
      next_oe     = '0;
      next_out    = '0;
      next_ie     = '0;
      next_tap    = '0;
      next_analog = '0;
    end
  end

  // Output registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_pullup_en     <= '0;
      pad_oe            <= '0;
      pad_out           <= '0;
      pad_input_en      <= '0;
      digital_input_tap <= '0;
      analog_path       <= '0;
    end
    else
    begin
      pad_pullup_en     <= next_pullup;
      pad_oe            <= next_oe;
      pad_out           <= next_out;
      pad_input_en      <= next_ie;
      digital_input_tap <= next_tap;
      analog_path       <= next_analog;
    end
  end

endmodule // pcm_port_ovr
`default_nettype wire

// ### dv/pcm_pins.sv
// Far-side model of the shared pins: external sources, pull-ups and floating noise.
`timescale 1ns/100ps
`default_nettype none
module pcm_pins
#(
  parameter int unsigned W = 8
)
(
  input  wire logic         pclk,
  input  wire logic [W-1:0] drv_en,
  input  wire logic [W-1:0] drv_val,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] pullup_en,
  output var  logic [W-1:0] level
);
  logic [W-1:0] float_q = '0;

  // A floating pin toggles, so it never settles into a lucky match.
  always @(posedge pclk)
  begin
    float_q <= ~float_q;
  end

  // The device wins while it drives, then the source, then pull-up or noise.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (pad_oe[i])
        level[i] = pad_out[i];
      else if (drv_en[i])
        level[i] = drv_val[i];
      else
        level[i] = pullup_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule // pcm_pins
`default_nettype wire

// ### dv/pcm_mux_tb.sv
// Self-checking testbench of the port H/J pin-change and segment mux.
`timescale 1ns/100ps
`default_nettype none
module pcm_mux_tb;
  import pcm_pkg::*;

  // ==========================================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        e;
  logic [7:0]  h_pu, h_dir, h_out, h_ie, h_drv, h_val, ph_in;
  logic [7:0]  ph_out, ph_oe, ph_pu, ph_ie, ph_an;
  logic [6:0]  j_pu, j_dir, j_out, j_ie, j_drv, j_val, pj_in;
  logic [6:0]  pj_out, pj_oe, pj_pu, pj_ie, pj_an;
  logic [39:0] seg;
  logic [30:16] pcs;
  logic [7:0]  eh;
  logic [6:0]  ej;
  logic [31:0] prdata_s, rs;
  logic [30:16] pcs_s;
  logic [7:0]  ph_oe_s, ph_pu_s;
  logic [6:0]  pj_oe_s;
  int          errors, checks_done, cycles;
  int          hseg [8] = '{10, 9, 8, 7, 39, 38, 37, 36};
  int          jseg [7] = '{35, 34, 31, 30, 29, 28, 27};

  // ==========================================================================
  // Design, pin models and clock
  pcm_mux uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_h_pullup(h_pu), .port_h_dir(h_dir), .port_h_out(h_out),
    .port_h_input_enable(h_ie), .port_j_pullup(j_pu), .port_j_dir(j_dir),
    .port_j_out(j_out), .port_j_input_enable(j_ie), .ph_pad_in(ph_in),
    .ph_pad_out(ph_out), .ph_pad_oe(ph_oe), .ph_pullup_en(ph_pu),
    .ph_input_en(ph_ie), .ph_analog_path(ph_an), .pj_pad_in(pj_in),
    .pj_pad_out(pj_out), .pj_pad_oe(pj_oe), .pj_pullup_en(pj_pu),
    .pj_input_en(pj_ie), .pj_analog_path(pj_an),
    .lcd_front_plane_output(seg), .pin_change_source(pcs));
  pcm_pins #(.W(8)) pins_h (.pclk(pclk), .drv_en(h_drv), .drv_val(h_val),
    .pad_oe(ph_oe), .pad_out(ph_out), .pullup_en(ph_pu), .level(ph_in));
  pcm_pins #(.W(7)) pins_j (.pclk(pclk), .drv_en(j_drv), .drv_val(j_val),
    .pad_oe(pj_oe), .pad_out(pj_out), .pullup_en(pj_pu), .level(pj_in));
  // Small variant on the same stimulus: ports H and J must stay dead.
  pcm_mux #(.LARGE_PKG(1'b0)) uut_small (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_s), .pready(), .pslverr(),
    .port_h_pullup(h_pu), .port_h_dir(h_dir), .port_h_out(h_out),
    .port_h_input_enable(h_ie), .port_j_pullup(j_pu), .port_j_dir(j_dir),
    .port_j_out(j_out), .port_j_input_enable(j_ie), .ph_pad_in(ph_in),
    .ph_pad_out(), .ph_pad_oe(ph_oe_s), .ph_pullup_en(ph_pu_s),
    .ph_input_en(), .ph_analog_path(), .pj_pad_in(pj_in),
    .pj_pad_out(), .pj_pad_oe(pj_oe_s), .pj_pullup_en(),
    .pj_input_en(), .pj_analog_path(),
    .lcd_front_plane_output(seg), .pin_change_source(pcs_s));

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [39:0] exp,
                     input logic [39:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    r  = prdata;
    rs = prdata_s;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(nm, {8'h00, x}, {8'h00, r});
    chk("pslverr", {39'h0, xe}, {39'h0, e});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      final_report;
    end
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, seg} = '0;
    {h_pu, h_dir, h_out, h_ie, h_drv, h_val} = '0;
    {j_pu, j_dir, j_out, j_ie, j_drv, j_val} = '0;
    presetn = 1'b0;
    settle(16);
    presetn <= 1'b1;
    rd("ctrl", PCM_CTRL_OFF, 32'h0, 1'b0);
    rd("mask", PCM_MASK_OFF, 32'h0, 1'b0);
    rd("stat", PCM_STAT_OFF, 32'h0001_0000, 1'b0);
    chk("stat_small", 32'h0, rs);
    rd("unmapped", 8'h0c, 32'h0, 1'b1);
    apb(1'b1, PCM_STAT_OFF, 32'hffff_ffff);
    rd("stat_ro", PCM_STAT_OFF, 32'h0001_0000, 1'b0);
    // LCD off: pads follow the port controls.
    {h_pu, h_dir, h_out} <= {8'hff, 8'hff, 8'ha5};
    {j_pu, j_dir, j_out} <= {7'h7f, 7'h7f, 7'h55};
    settle(3);
    chk("pu", {8'hff, 7'h7f}, {ph_pu, pj_pu});
    chk("oe", {8'hff, 7'h7f}, {ph_oe, pj_oe});
    chk("pads_small", 23'h0, {ph_oe_s, pj_oe_s, ph_pu_s});
    // LCD on: pull-ups off and inputs forced, output value untouched.
    apb(1'b1, PCM_CTRL_OFF, 32'h1);
    settle(3);
    chk("pu_lcd", 15'h0, {ph_pu, pj_pu});
    chk("oe_lcd", 15'h0, {ph_oe, pj_oe});
    chk("out_lcd", {8'ha5, 7'h55}, {ph_out, pj_out});
    // Every control combination of the input enable override.
    apb(1'b1, PCM_MASK_OFF, 32'h335a);
    {h_ie, j_ie} <= {8'h81, 7'h40};
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, PCM_CTRL_OFF, c);
      settle(3);
      eh = (c == 7) ? 8'hdb : 8'h81;
      ej = (c == 7) ? 7'h73 : 7'h40;
      chk("ie", {eh, ej}, {ph_ie, pj_ie});
    end
    // Walk one high pin per port through every pin-change source.
    apb(1'b1, PCM_MASK_OFF, 32'h7fff);
    {h_drv, j_drv} <= '1;
    for (int i = 0; i < 8; i++)
    begin
      eh = 8'h1 << i;
      ej = 7'(8'h1 << i);
      {h_val, j_val} <= {eh, ej};
      settle(8);
      chk("pcs_h", eh, pcs[23:16]);
      chk("pcs_j", ej, pcs[30:24]);
      chk("pcs_small", 15'h0, pcs_s);
      rd("stat_taps", PCM_STAT_OFF, {16'h0001, 1'b0, ej, eh}, 1'b0);
    end
    // Walk a single lit segment across the whole front plane.
    for (int s = 0; s < 40; s++)
    begin
      seg <= 40'h1 << s;
      settle(3);
      foreach (eh[b])
        eh[b] = (hseg[b] == s);
      foreach (ej[b])
        ej[b] = (jseg[b] == s);
      chk("seg_h", eh, ph_an);
      chk("seg_j", ej, pj_an);
    end
    // LCD off again: overrides released and the driven pad reads back.
    {h_ie, j_ie} <= {8'hff, 7'h7f};
    apb(1'b1, PCM_CTRL_OFF, 32'h0);
    settle(8);
    chk("pu_off", {8'hff, 7'h7f}, {ph_pu, pj_pu});
    chk("oe_off", {8'hff, 7'h7f}, {ph_oe, pj_oe});
    chk("pcs_off", {7'h55, 8'ha5}, pcs);
    final_report;
  end
endmodule // pcm_mux_tb
`default_nettype wire
